// file: midi_filter_regs.vh
// Constants for the MIDI message filter and dispatcher: register offsets,
// field positions, reset values and MIDI codes.
// Assumes inclusion by bare name from the design files.
`ifndef MIDI_FILTER_REGS_VH
`define MIDI_FILTER_REGS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OFS_CTRL 10'h000
`define OFS_STATUS 10'h004
`define OFS_PGM_BASE 10'h200

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define BIT_PC_TX_EN 0
`define BIT_PC_ECHO 1
`define BIT_PC_RX_EN 2
`define BIT_PC_ANY 3
`define BIT_CC_TX_EN 4
`define BIT_CC_ECHO 5
`define BIT_CC_RX_EN 6
`define BIT_CC_ANY 7
`define POS_CC_MODE 8
`define POS_TX_PORT 12
`define POS_RX_PORT 16
`define POS_TX_CHAN 20
`define POS_RX_CHAN 24
`define CTRL_WMASK 32'h0FF773FF
`define CTRL_RESET 32'h00000100

// ----------------------------------------------------------------
// Port codes, mapping modes, parameter kinds
// ----------------------------------------------------------------
`define PORT_MIDI 3'h0
`define PORT_USB1 3'h1
`define PORT_USB2 3'h2
`define PORT_USB3 3'h3
`define PORT_SLOT 3'h4
`define MODE_ONE 2'h1
`define MODE_TWO 2'h2
`define MODE_THREE 2'h3
`define KIND_FADER 2'h0
`define KIND_PAN 2'h1
`define KIND_SEND1 2'h2
`define KIND_SEND2 2'h3

// ----------------------------------------------------------------
// MIDI status nibbles and controller numbers
// ----------------------------------------------------------------
`define ST_CTRL_CHANGE 4'hB
`define ST_PROG_CHANGE 4'hC
`define CC_FADER 7'h07
`define CC_PAN 7'h0A
`define CC_SEND1 7'h5B
`define CC_SEND2 7'h5D
`define CC_MODE2_FIRST 7'h01
`define CC_MODE2_LAST 7'h10

`endif

// file: cc_parameter_map.v
// Controller number to mix parameter translation, both directions.
// Assumes a combinational use by the dispatcher; no state of its own.
`timescale 1ns/1ps
`default_nettype none
`include "midi_filter_regs.vh"

module cc_parameter_map (
    input wire [1:0] mode,
    input wire [3:0] rx_channel_in,
    input wire [6:0] rx_number,
    output reg rx_hit,
    output reg [1:0] rx_kind,
    output reg [3:0] rx_track,
    input wire [1:0] tx_kind,
    input wire [3:0] tx_track,
    input wire [3:0] tx_base_channel,
    output reg tx_hit,
    output reg [3:0] tx_channel_out,
    output reg [6:0] tx_number
);

    // ----------------------------------------------------------------
    // Incoming controller to parameter
    // ----------------------------------------------------------------
    always @* begin
        rx_hit = 1'b0;
        rx_kind = `KIND_FADER;
        rx_track = 4'h0;
        if (mode == `MODE_ONE) begin
            // Channel number selects the track of the same number
            rx_track = rx_channel_in;
            rx_hit = 1'b1;
            // Fixed controller set per track
            case (rx_number)
                `CC_FADER: rx_kind = `KIND_FADER;
                `CC_PAN: rx_kind = `KIND_PAN;
                `CC_SEND1: rx_kind = `KIND_SEND1;
                `CC_SEND2: rx_kind = `KIND_SEND2;
                default: rx_hit = 1'b0; // Unmapped number
            endcase
        end else if (mode == `MODE_TWO) begin
            // Controllers 1..16 drive input faders 1..16
            if (rx_number >= `CC_MODE2_FIRST && rx_number <= `CC_MODE2_LAST) begin
                rx_hit = 1'b1;
                rx_track = rx_number[3:0] - 4'h1;
            end
        end
        // Mode three: its own table is not held, nothing matches
    end

    // ----------------------------------------------------------------
    // Operated parameter to outgoing controller
    // ----------------------------------------------------------------
    always @* begin
        tx_hit = 1'b0;
        tx_channel_out = tx_base_channel;
        tx_number = `CC_FADER;
        if (mode == `MODE_ONE) begin
            tx_hit = 1'b1;
            tx_channel_out = tx_track;
            case (tx_kind)
                `KIND_FADER: tx_number = `CC_FADER;
                `KIND_PAN: tx_number = `CC_PAN;
                `KIND_SEND1: tx_number = `CC_SEND1;
                default: tx_number = `CC_SEND2;
            endcase
        end else if (mode == `MODE_TWO) begin
            // Single configured channel, faders only
            if (tx_kind == `KIND_FADER) begin
                tx_hit = 1'b1;
                tx_number = {3'h0, tx_track} + 7'h01;
            end
        end
    end

endmodule
`default_nettype wire

// file: midi_message_filter_dispatch.v
// Program change and control change filter and dispatcher between the
// mixer core and external MIDI traffic, with an Avalon-MM register slave.
// Assumes all message and event inputs come from logic on the same clock,
// already parsed into whole messages, and held until acknowledged.
`timescale 1ns/1ps
`default_nettype none
`include "midi_filter_regs.vh"

module midi_message_filter_dispatch #(
    parameter ADDR_W = 10,
    parameter PGM_DEPTH = 128
) (
    input wire clock,
    input wire rst,

    // Avalon-MM register slave
    input wire [ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,

    // Received message stream
    input wire rx_valid,
    input wire [2:0] rx_port,
    input wire [7:0] rx_status,
    input wire [6:0] rx_data1,
    input wire [6:0] rx_data2,
    output reg rx_ack,

    // Scene recall events from the panel
    input wire scene_valid,
    input wire [6:0] scene_number,
    output reg scene_ack,

    // Mix parameter operations from the panel
    input wire param_valid,
    input wire [1:0] param_kind,
    input wire [3:0] param_track,
    input wire [6:0] param_value,
    output reg param_ack,

    // Transmitted message stream
    output reg tx_valid,
    input wire tx_ready,
    output reg [2:0] tx_port,
    output reg [7:0] tx_status,
    output reg [6:0] tx_data1,
    output reg [6:0] tx_data2,

    // Scene recall request to the mixer core
    output reg recall_valid,
    output reg [6:0] recall_scene,

    // Mix parameter update request to the mixer core
    output reg update_valid,
    output reg [1:0] update_kind,
    output reg [3:0] update_track,
    output reg [6:0] update_value
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [31:0] ctrl; // Enables, mode, ports, channels
    reg [15:0] accept_count; // Received messages acted upon
    reg [15:0] drop_count; // Received messages ignored

    // Scene assignment table
    reg [6:0] pgm_map [0:PGM_DEPTH-1]; // Program number to scene number
    integer i; // Reset loop index

    // Control fields
    // Program change enables and accept_any_channel
    wire pc_tx_en = ctrl[`BIT_PC_TX_EN];
    wire pc_echo = ctrl[`BIT_PC_ECHO];
    wire pc_rx_en = ctrl[`BIT_PC_RX_EN];
    wire pc_accept_any_channel = ctrl[`BIT_PC_ANY];

    // Control change enables and accept_any_channel
    wire cc_tx_en = ctrl[`BIT_CC_TX_EN];
    wire cc_echo = ctrl[`BIT_CC_ECHO];
    wire cc_rx_en = ctrl[`BIT_CC_RX_EN];
    wire cc_accept_any_channel = ctrl[`BIT_CC_ANY];

    // Mode, link ports, channel codes
    wire [1:0] cc_mode = ctrl[`POS_CC_MODE+1:`POS_CC_MODE];
    wire [2:0] sel_tx_port = ctrl[`POS_TX_PORT+2:`POS_TX_PORT];
    wire [2:0] sel_rx_port = ctrl[`POS_RX_PORT+2:`POS_RX_PORT];
    wire [3:0] tx_chan = ctrl[`POS_TX_CHAN+3:`POS_TX_CHAN];
    wire [3:0] rx_chan = ctrl[`POS_RX_CHAN+3:`POS_RX_CHAN];

    // ----------------------------------------------------------------
    // Controller mapping
    // ----------------------------------------------------------------
    wire map_rx_hit; // Received controller has a parameter
    wire [1:0] map_rx_kind; // Parameter kind of received controller
    wire [3:0] map_rx_track; // Track of received controller
    wire map_tx_hit; // Operated parameter has a controller
    wire [3:0] map_tx_chan; // Channel for outgoing controller
    wire [6:0] map_tx_num; // Number for outgoing controller

    // One translator for both directions
    cc_parameter_map u_map (
        .mode(cc_mode),
        // Receive side
        .rx_channel_in(rx_status[3:0]),
        .rx_number(rx_data1),
        .rx_hit(map_rx_hit),
        .rx_kind(map_rx_kind),
        .rx_track(map_rx_track),
        // Transmit side
        .tx_kind(param_kind),
        .tx_track(param_track),
        .tx_base_channel(tx_chan),
        .tx_hit(map_tx_hit),
        .tx_channel_out(map_tx_chan),
        .tx_number(map_tx_num)
    );

    // ----------------------------------------------------------------
    // Receive classification
    // ----------------------------------------------------------------
    // Only a legal, selected receive port passes
    wire port_ok = (rx_port == sel_rx_port) && (rx_port <= `PORT_SLOT);

    // Message type from the status nibble
    wire is_pc = (rx_status[7:4] == `ST_PROG_CHANGE);
    wire is_cc = (rx_status[7:4] == `ST_CTRL_CHANGE);
    wire chan_match = (rx_status[3:0] == rx_chan);

    // Program change channel test, bypassed by accept_any_channel
    wire pc_accept = port_ok && is_pc && pc_rx_en && (pc_accept_any_channel || chan_match);

    // Mode one takes all sixteen channels; other modes one channel unless accept_any_channel is set
    wire cc_chan_ok = (cc_mode == `MODE_ONE) || cc_accept_any_channel || chan_match;

    // Accept_any_channel opens every channel unmapped numbers drop
    wire cc_accept = port_ok && is_cc && cc_rx_en && cc_chan_ok && map_rx_hit;

    // Echo applies to every received message of the type on the port
    wire pc_echo_go = port_ok && is_pc && pc_echo;
    wire cc_echo_go = port_ok && is_cc && cc_echo;

    // Codes above the slot port send nothing
    wire tx_port_ok = (sel_tx_port <= `PORT_SLOT);

    // ----------------------------------------------------------------
    // Request arbitration
    // ----------------------------------------------------------------
    // A request is taken only with the output slot empty and no
    // acknowledge pending, so a held request is never taken twice.
    wire slot_free = !tx_valid && !rx_ack && !scene_ack && !param_ack;

    // Received traffic first, then scenes, then parameters
    wire take_rx = slot_free && rx_valid;
    wire take_scene = slot_free && !rx_valid && scene_valid;
    wire take_param = slot_free && !rx_valid && !scene_valid && param_valid;

    // ----------------------------------------------------------------
    // Message dispatch
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            rx_ack <= 1'b0;
            scene_ack <= 1'b0;
            param_ack <= 1'b0;

            // Output slot empty
            tx_valid <= 1'b0;
            tx_port <= `PORT_MIDI;
            tx_status <= 8'h00;
            tx_data1 <= 7'h00;
            tx_data2 <= 7'h00;

            // Core requests idle
            recall_valid <= 1'b0;
            recall_scene <= 7'h00;
            update_valid <= 1'b0;
            update_kind <= `KIND_FADER;
            update_track <= 4'h0;
            update_value <= 7'h00;

            // Status counters from zero
            accept_count <= 16'h0000;
            drop_count <= 16'h0000;
        end else begin
            // Acknowledges and core requests are single pulses
            rx_ack <= take_rx;
            scene_ack <= take_scene;
            param_ack <= take_param;
            recall_valid <= 1'b0;
            update_valid <= 1'b0;

            // Output slot empties when the link takes it
            if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
            end

            if (take_rx) begin
                // Received message: echo, then act on it
                if ((pc_echo_go || cc_echo_go) && tx_port_ok) begin
                    tx_valid <= 1'b1;
                    tx_port <= sel_tx_port;
                    tx_status <= rx_status;
                    tx_data1 <= rx_data1;
                    tx_data2 <= rx_data2;
                end

                if (pc_accept) begin
                    // Program number selects the assigned scene
                    recall_valid <= 1'b1;
                    recall_scene <= pgm_map[rx_data1];
                end

                if (cc_accept) begin
                    // Mapped parameter takes the controller value
                    update_valid <= 1'b1;
                    update_kind <= map_rx_kind;
                    update_track <= map_rx_track;
                    update_value <= rx_data2;
                end

                // Each taken message counted once
                if (pc_accept || cc_accept) begin
                    accept_count <= accept_count + 16'h0001;
                end else begin
                    drop_count <= drop_count + 16'h0001;
                end
            end else if (take_scene) begin
                // Scene recall sends its program change
                if (pc_tx_en && tx_port_ok) begin
                    tx_valid <= 1'b1;
                    tx_port <= sel_tx_port;
                    tx_status <= {`ST_PROG_CHANGE, tx_chan};
                    tx_data1 <= scene_number;
                    tx_data2 <= 7'h00;
                end
            end else if (take_param) begin
                // Operated parameter sends its controller
                if (cc_tx_en && map_tx_hit && tx_port_ok) begin
                    tx_valid <= 1'b1;
                    tx_port <= sel_tx_port;
                    tx_status <= {`ST_CTRL_CHANGE, map_tx_chan};
                    tx_data1 <= map_tx_num;
                    tx_data2 <= param_value;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave
    // ----------------------------------------------------------------
    // Waitrequest stands high; a request gets one low cycle, in which
    // a write takes effect and read data stand.
    wire req = avs_read || avs_write;
    wire wr_now = avs_write && !avs_waitrequest;

    // Address decode
    wire is_ctrl = (avs_address == `OFS_CTRL);
    wire is_status = (avs_address == `OFS_STATUS);
    wire is_pgm = (avs_address >= `OFS_PGM_BASE)
        && (avs_address < `OFS_PGM_BASE + PGM_DEPTH * 4)
        && (avs_address[1:0] == 2'h0);

    // Table word index
    wire [ADDR_W-1:0] pgm_ofs = avs_address - `OFS_PGM_BASE;
    wire [6:0] pgm_idx = pgm_ofs[8:2];

    // Byte-lane merge for the control register
    reg [31:0] next_ctrl;
    always @* begin
        next_ctrl = ctrl;
        if (avs_byteenable[0]) next_ctrl[7:0] = avs_writedata[7:0];
        if (avs_byteenable[1]) next_ctrl[15:8] = avs_writedata[15:8];
        if (avs_byteenable[2]) next_ctrl[23:16] = avs_writedata[23:16];
        if (avs_byteenable[3]) next_ctrl[31:24] = avs_writedata[31:24];
        // Reserved bits read as zero
        next_ctrl = next_ctrl & `CTRL_WMASK;
    end

    // Handshake, writes and read data
    always @(posedge clock) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            ctrl <= `CTRL_RESET;

            // Program number n recalls scene n until reassigned
            for (i = 0; i < PGM_DEPTH; i = i + 1) begin
                pgm_map[i] <= i[6:0];
            end
        end else begin
            // One low cycle per request
            avs_waitrequest <= !(req && avs_waitrequest);

            // Read data for the low cycle
            if (req && avs_waitrequest) begin
                // Unmapped addresses read as zero
                if (is_ctrl) begin
                    avs_readdata <= ctrl;
                end else if (is_status) begin
                    avs_readdata <= {drop_count, accept_count};
                end else if (is_pgm) begin
                    avs_readdata <= {25'h0000000, pgm_map[pgm_idx]};
                end else begin
                    avs_readdata <= 32'h00000000;
                end
            end

            if (wr_now && is_ctrl) begin
                // Channels 1..16 held as codes 0..15
                ctrl <= next_ctrl;
            end

            // Table takes the low lane only
            if (wr_now && is_pgm && avs_byteenable[0]) begin
                pgm_map[pgm_idx] <= avs_writedata[6:0];
            end
        end
    end

endmodule
`default_nettype wire

// file: midi_filter_monitor.sv
// Concurrent checks on the message filter and dispatcher ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "midi_filter_regs.vh"
module midi_filter_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic avs_waitrequest,
    input wire logic [7:0] rx_status,
    input wire logic [6:0] rx_data1,
    input wire logic [6:0] rx_data2,
    input wire logic rx_ack,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [2:0] tx_port,
    input wire logic [7:0] tx_status,
    input wire logic [6:0] tx_data1,
    input wire logic [6:0] tx_data2,
    input wire logic recall_valid,
    input wire logic update_valid,
    input wire logic [1:0] update_kind,
    input wire logic [3:0] update_track,
    input wire logic [6:0] update_value
);
// ----------------------------------------------------------------
// Properties
// ----------------------------------------------------------------
default clocking cb @(posedge clock); endclocking
default disable iff (rst);
// Bus answer lasts one cycle only
chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");
// Outgoing message holds until taken
chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_port,
    tx_status, tx_data1, tx_data2})) else $error("tx changed while waiting");
chk_echo_same: assert property (rx_ack && tx_valid && !$past(tx_valid) |->
    tx_status == $past(rx_status) && tx_data1 == $past(rx_data1)
    && tx_data2 == $past(rx_data2)) else $error("echo differs from received message");
chk_recall_cause: assert property (recall_valid |-> rx_ack &&
    $past(rx_status[7:4]) == `ST_PROG_CHANGE) else $error("recall without program change");
chk_update_cause: assert property (update_valid |-> rx_ack &&
    $past(rx_status[7:4]) == `ST_CTRL_CHANGE && update_value == $past(rx_data2))
    else $error("update without control change");
chk_mode1_map: assert property (update_valid && update_kind != `KIND_FADER |->
    update_track == $past(rx_status[3:0]) && $past(rx_data1) == (update_kind == `KIND_PAN ?
    `CC_PAN : update_kind == `KIND_SEND1 ? `CC_SEND1 : `CC_SEND2))
    else $error("controller maps to wrong parameter");
chk_fader_number: assert property (update_valid && update_kind == `KIND_FADER
    |-> $past(rx_data1) == `CC_FADER || $past(rx_data1) == {3'h0, update_track} + 7'h01)
    else $error("fader from wrong controller");
chk_port_legal: assert property (tx_valid |-> tx_port <= `PORT_SLOT)
    else $error("tx port out of range");
chk_status_kind: assert property (tx_valid |-> tx_status[7:4] == `ST_CTRL_CHANGE
    || tx_status[7:4] == `ST_PROG_CHANGE) else $error("tx status of other kind");
endmodule
bind midi_message_filter_dispatch midi_filter_monitor midi_filter_monitor_i (.clock, .rst,
    .avs_waitrequest, .rx_status, .rx_data1, .rx_data2, .rx_ack, .tx_valid, .tx_ready,
    .tx_port, .tx_status, .tx_data1, .tx_data2, .recall_valid, .update_valid,
    .update_kind, .update_track, .update_value);
`default_nettype wire

// file: midi_far_end.sv
// Model of the external MIDI device: sends whole messages, sinks output.
// Assumes the bench calls send right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module midi_far_end (
    input wire logic clock,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [2:0] tx_port,
    input wire logic [7:0] tx_status,
    input wire logic [6:0] tx_data1,
    input wire logic [6:0] tx_data2,
    input wire logic rx_ack,
    output logic tx_ready,
    output logic rx_valid,
    output logic [2:0] rx_port,
    output logic [7:0] rx_status,
    output logic [6:0] rx_data1,
    output logic [6:0] rx_data2
);
// ----------------------------------------------------------------
// Sink and source
// ----------------------------------------------------------------
logic [1:0] pace = 2'h0; // Slow mode takes one message in four cycles
logic [31:0] got_n = 32'h0; // Messages taken
logic [31:0] got_hi = 32'h0; // Last port, status, first data byte
logic [6:0] got_d2 = 7'h00; // Last second data byte
initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    {rx_port, rx_status, rx_data1, rx_data2} = 25'h0;
end
// Take an output message whenever ready meets valid
always @(posedge clock) begin
    pace <= pace + 2'h1;
    tx_ready <= !slow || pace == 2'h3;
    if (tx_valid && tx_ready) begin
        got_n <= got_n + 32'h1;
        got_hi <= {14'h0, tx_port, tx_status, tx_data1};
        got_d2 <= tx_data2;
    end
end
// Offer one message, hold it until acknowledged, then scramble the idle lines
task send(input logic [2:0] p, input logic [7:0] s, input logic [6:0] a, input logic [6:0] b);
    rx_port <= p;
    rx_status <= s;
    rx_data1 <= a;
    rx_data2 <= b;
    rx_valid <= 1'b1;
    do @(posedge clock); while (rx_ack !== 1'b1);
    rx_valid <= 1'b0;
    {rx_port, rx_status, rx_data1, rx_data2} <= ~{p, s, a, b};
endtask
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the message filter and dispatcher.
// Assumes the far-end model and the bound monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "midi_filter_regs.vh"
module tb;
// ----------------------------------------------------------------
// Signals and instances
// ----------------------------------------------------------------
logic clock, rst, avs_read, avs_write, avs_waitrequest, rx_valid, rx_ack, slow;
logic scene_valid, scene_ack, param_valid, param_ack, tx_valid, tx_ready;
logic recall_valid, update_valid;
logic [9:0] avs_address;
logic [31:0] avs_writedata, avs_readdata, q, n0, r0, u0;
logic [3:0] avs_byteenable, param_track, update_track;
logic [2:0] rx_port, tx_port;
logic [7:0] rx_status, tx_status;
logic [6:0] rx_data1, rx_data2, scene_number, param_value, tx_data1, tx_data2;
logic [6:0] recall_scene, update_value;
logic [1:0] param_kind, update_kind;
logic [31:0] rec_n = 32'h0; // Recall pulses seen
logic [31:0] upd_n = 32'h0; // Update pulses seen
int checked = 0;
int miscompares = 0;
logic [6:0] num [4] = '{`CC_FADER, `CC_PAN, `CC_SEND1, `CC_SEND2};
midi_message_filter_dispatch midi_message_filter_dispatch_i (.clock, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .rx_valid, .rx_port, .rx_status, .rx_data1, .rx_data2, .rx_ack, .scene_valid,
    .scene_number, .scene_ack, .param_valid, .param_kind, .param_track, .param_value,
    .param_ack, .tx_valid, .tx_ready, .tx_port, .tx_status, .tx_data1, .tx_data2,
    .recall_valid, .recall_scene, .update_valid, .update_kind, .update_track, .update_value);
midi_far_end midi_far_end_i (.clock, .slow, .tx_valid, .tx_port, .tx_status, .tx_data1,
    .tx_data2, .rx_ack, .tx_ready, .rx_valid, .rx_port, .rx_status, .rx_data1, .rx_data2);
always #50 clock = ~clock;
// Count one-cycle pulses towards the mixer core
always @(posedge clock) begin
    if (recall_valid === 1'b1) rec_n <= rec_n + 32'h1;
    if (update_valid === 1'b1) upd_n <= upd_n + 32'h1;
end
// ----------------------------------------------------------------
// Tasks
// ----------------------------------------------------------------
task conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
endtask
// One register access, held until waitrequest is seen low
task bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
endtask
// Let any pending output message be taken
task drain;
    @(posedge clock);
    while (tx_valid === 1'b1) @(posedge clock);
    @(posedge clock);
endtask
task rx(input logic [7:0] s, input logic [6:0] a, input logic [6:0] b, input logic [2:0] p = 3'h1);
    n0 = midi_far_end_i.got_n;
    r0 = rec_n;
    u0 = upd_n;
    midi_far_end_i.send(p, s, a, b);
    drain;
endtask
task param(input logic [1:0] k, input logic [3:0] t, input logic [6:0] v);
    n0 = midi_far_end_i.got_n;
    {param_kind, param_track, param_value} <= {k, t, v};
    param_valid <= 1'b1;
    do @(posedge clock); while (param_ack !== 1'b1);
    param_valid <= 1'b0;
    drain;
endtask
task tx_is(input logic [17:0] e);
    chk(midi_far_end_i.got_n, n0 + 32'h1);
    chk(midi_far_end_i.got_hi, {14'h0, e});
endtask
// ----------------------------------------------------------------
// Sequence
// ----------------------------------------------------------------
initial begin
    #(100 * 6000);
    miscompares++;
    conclude;
end
initial begin
    {clock, rst, avs_read, avs_write, avs_address, avs_writedata} = 46'h100000000000;
    {scene_valid, scene_number, param_valid, param_kind, param_track, param_value} = 22'h0;
    avs_byteenable = 4'hF;
    slow = 1'b0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(0, `OFS_CTRL, 0, q); chk(q, `CTRL_RESET);
    bus(0, `OFS_STATUS, 0, q); chk(q, 32'h0);
    bus(1, `OFS_CTRL, 32'hF3512177, q);
    bus(0, `OFS_CTRL, 0, q); chk(q, 32'h03512177);
    bus(1, 10'h008, 32'hFFFFFFFF, q);
    bus(0, 10'h008, 0, q); chk(q, 32'h0);
    bus(1, `OFS_PGM_BASE + 10'h024, 32'h33, q);
    bus(0, `OFS_PGM_BASE + 10'h024, 0, q); chk(q, 32'h33);
    n0 = midi_far_end_i.got_n;
    scene_number <= 7'h2A;
    scene_valid <= 1'b1;
    do @(posedge clock); while (scene_ack !== 1'b1);
    scene_valid <= 1'b0;
    drain;
    tx_is({3'h2, 8'hC5, 7'h2A});
    rx(8'hC3, 7'h09, 7'h00);
    tx_is({3'h2, 8'hC3, 7'h09});
    chk(rec_n, r0 + 32'h1); chk({25'h0, recall_scene}, 32'h33);
    rx(8'hC4, 7'h09, 7'h00);
    tx_is({3'h2, 8'hC4, 7'h09}); chk(rec_n, r0);
    bus(1, `OFS_CTRL, 32'h0351217F, q);
    rx(8'hC4, 7'h00, 7'h00);
    chk(rec_n, r0 + 32'h1); chk({25'h0, recall_scene}, 32'h0);
    rx(8'hC3, 7'h09, 7'h00, 3'h0);
    chk(midi_far_end_i.got_n, n0); chk(rec_n, r0);
    slow <= 1'b1;
    for (int k = 0; k < 4; k++) begin
        rx(8'hB9, num[k], {5'h10, k[1:0]});
        chk(upd_n, u0 + 32'h1);
        chk({19'h0, update_kind, update_track, update_value}, {19'h0, k[1:0], 4'h9, 5'h10,
            k[1:0]});
        tx_is({3'h2, 8'hB9, num[k]});
        chk({25'h0, midi_far_end_i.got_d2}, {25'h0, 5'h10, k[1:0]});
    end
    rx(8'hB9, 7'h14, 7'h01); chk(upd_n, u0);
    for (int k = 0; k < 4; k++) begin
        param(k[1:0], 4'h4, {5'h08, k[1:0]});
        tx_is({3'h2, 8'hB4, num[k]});
        chk({25'h0, midi_far_end_i.got_d2}, {25'h0, 5'h08, k[1:0]});
    end
    slow <= 1'b0;
    bus(1, `OFS_CTRL, 32'h0351227F, q);
    rx(8'hB3, 7'h05, 7'h11);
    chk(upd_n, u0 + 32'h1); chk({26'h0, update_kind, update_track}, 32'h4);
    rx(8'hB2, 7'h05, 7'h00); chk(upd_n, u0);
    param(2'h0, 4'h6, 7'h22); tx_is({3'h2, 8'hB5, 7'h07});
    param(2'h1, 4'h6, 7'h22); chk(midi_far_end_i.got_n, n0);
    bus(1, `OFS_CTRL, 32'h035122FF, q);
    rx(8'hB2, 7'h10, 7'h00);
    chk(upd_n, u0 + 32'h1); chk({28'h0, update_track}, 32'hF);
    bus(1, `OFS_CTRL, 32'h035123FF, q);
    rx(8'hB3, 7'h07, 7'h00); chk(upd_n, u0);
    bus(0, `OFS_STATUS, 0, q); chk(q, {16'h0005, 16'h0008});
    conclude;
end
endmodule
`default_nettype wire
